/* tswx_pkg.sv */
// constants and types for the terminal status word exchange
// Notes on behaviour
// - Updated entry number written as three BCD digits
// - Strobe returns to 0 after delivery
// - Link relay 0-199 maps to io words 1000-1199
// - Control bit 15 falling to 0 blanks display
// - Bit 15 rise or key relights display
// - Screen switch command also lights display
// - Control bits never updated by terminal
// - Bit 5 rise prints history once
// - Bit 4 rise prints daily report once
// - Idle timeout turns backlight off when enabled
// - Control word at startup is ignored
// - Numeral strobe sits at notify bit 11
package tswx_pkg;
	localparam int WORD_W = 16;
	localparam int CTL_SCREEN_BIT = 15;
	localparam int CTL_HIST_BIT = 5;
	localparam int CTL_DAILY_BIT = 4;
	localparam int NTF_RUN_BIT = 15;
	localparam int NTF_STROBE_BIT = 11;
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
	localparam logic [15:0] LINK_AREA_FIRST = 16'h0000;
	localparam logic [15:0] LINK_AREA_LAST = 16'h00C7;
	localparam logic [15:0] LINK_TO_IO_BASE = 16'h03E8;
	localparam logic [1:0] AREA_IO = 2'h0;
	localparam logic [1:0] AREA_LINK = 2'h1;
	localparam logic [1:0] AREA_OTHER = 2'h2;
	localparam int IDLE_TIME_MS = 60;
	localparam longint CLK_HZ = 250000000;
	localparam longint IDLE_CYCLES_DEF = (longint'(IDLE_TIME_MS) * CLK_HZ) / 1000;
	localparam int IDLE_W = 32;
	typedef enum logic [1:0] {TSWX_NTF_IDLE, TSWX_NTF_PENDING} tswx_ntf_type;
endpackage

/* tswx_terminal_status_word_exchange.sv */
// terminal side of the status notify and status control word exchange
`timescale 1ns/1ps
`default_nettype none
module tswx_terminal_status_word_exchange
	import tswx_pkg::*;
#(
	parameter logic [IDLE_W-1:0] IDLE_CYCLES = IDLE_W'(IDLE_CYCLES_DEF)
)(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [WORD_W-1:0] CTL_WORD,
	input wire logic CTL_POLL,
	input wire logic NUM_ENTERED,
	input wire logic [9:0] NUM_ENTRY,
	input wire logic NTF_DELIVERED,
	input wire logic RUN_MODE,
	input wire logic KEY_PRESS,
	input wire logic SCREEN_SWITCH,
	input wire logic IDLE_OFF_EN,
	input wire logic [1:0] ADDR_AREA,
	input wire logic [15:0] ADDR_IN,
	output logic [15:0] ADDR_OUT,
	output logic [1:0] ADDR_AREA_OUT,
	output logic [WORD_W-1:0] NOTIFY_WORD,
	output logic [WORD_W-1:0] ENTRY_WORD,
	output logic BACKLIGHT_ON,
	output logic HIST_PRINT,
	output logic DAILY_PRINT
);
	// every pin except reset, the entry number and the address pair is synchronised first;
	// the control word is only ever read, never written back, so it may disagree
	// with what the terminal really shows after a key press or an idle timeout

	// binary to three bcd digits
	function automatic logic [11:0] to_bcd3(input logic [9:0] bin);
		logic [11:0] d;
		logic [3:0] h;
		logic [3:0] t;
		logic [3:0] u;
		h = 4'((bin / 10'd100) % 10'd10);
		t = 4'((bin / 10'd10) % 10'd10);
		u = 4'(bin % 10'd10);
		d = {h, t, u};
		return d;
	endfunction

	// whole entry word: top nibble zero, then hundreds, tens and units
	function automatic logic [WORD_W-1:0] entry_word_of(input logic [9:0] bin);
		logic [WORD_W-1:0] w;
		w = {4'h0, to_bcd3(bin)};
		return w;
	endfunction

	// true when a configured address lies in the moved link relay words
	function automatic logic is_link_word(input logic [1:0] area, input logic [15:0] addr);
		logic hit;
		hit = 1'b0;
		if (area == AREA_LINK && addr >= LINK_AREA_FIRST && addr <= LINK_AREA_LAST) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	// link relay word number moved onto the io word area
	function automatic logic [15:0] link_to_io(input logic [15:0] addr);
		logic [15:0] moved;
		moved = addr + LINK_TO_IO_BASE;
		return moved;
	endfunction

	// single-bit pins gathered for the synchroniser
	logic [6:0] pin_raw;
	assign pin_raw[6] = CTL_POLL; // poll result valid
	assign pin_raw[5] = NUM_ENTERED; // operator finished an entry
	assign pin_raw[4] = NTF_DELIVERED; // notify word reached the controller
	assign pin_raw[3] = RUN_MODE; // terminal in run mode
	assign pin_raw[2] = KEY_PRESS; // any terminal key
	assign pin_raw[1] = SCREEN_SWITCH; // controller switched the screen
	assign pin_raw[0] = IDLE_OFF_EN; // idle backlight-off allowed

	// pins from outside pass two flip-flops; logic reads only the second
	logic [WORD_W-1:0] ctl_s1, ctl_s2, next_ctl_s1, next_ctl_s2;
	logic [6:0] pin_s1, pin_s2, next_pin_s1, next_pin_s2;
	always_comb begin
		next_ctl_s1 = CTL_WORD;
		next_ctl_s2 = ctl_s1;
		next_pin_s1 = pin_raw;
		next_pin_s2 = pin_s1;
	end
	// registers both synchroniser stages
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ctl_s1 <= WORD_RESET;
			ctl_s2 <= WORD_RESET;
			pin_s1 <= 7'h00;
			pin_s2 <= 7'h00;
		end else begin
			ctl_s1 <= next_ctl_s1;
			ctl_s2 <= next_ctl_s2;
			pin_s1 <= next_pin_s1;
			pin_s2 <= next_pin_s2;
		end
	end

	// synchronised pins by name
	logic poll, entered, delivered, run_mode, key, scr_sw, idle_en;
	assign poll = pin_s2[6];
	assign entered = pin_s2[5];
	assign delivered = pin_s2[4];
	assign run_mode = pin_s2[3];
	assign key = pin_s2[2];
	assign scr_sw = pin_s2[1];
	assign idle_en = pin_s2[0];

	// control word polling and edge detection
	logic [WORD_W-1:0] prev_ctl, next_prev_ctl;
	logic primed, next_primed;
	logic [WORD_W-1:0] rise, fall;
	always_comb begin
		next_prev_ctl = prev_ctl;
		next_primed = primed;
		rise = '0;
		fall = '0;
		if (poll) begin
			next_prev_ctl = ctl_s2;
			next_primed = 1'b1;
			if (primed) begin
				rise = ctl_s2 & ~prev_ctl;
				fall = ~ctl_s2 & prev_ctl;
			end
		end
	end
	// registers the previous poll and the primed flag
	always_ff @(posedge MCLK) begin
		if (RST) begin
			prev_ctl <= WORD_RESET;
			primed <= 1'b0;
		end else begin
			prev_ctl <= next_prev_ctl;
			primed <= next_primed;
		end
	end

	// qualified control-bit events; a bit held at 1 gives none
	logic screen_on_ev, screen_off_ev, hist_ev, daily_ev;
	assign screen_on_ev = rise[CTL_SCREEN_BIT];
	assign screen_off_ev = fall[CTL_SCREEN_BIT];
	assign hist_ev = rise[CTL_HIST_BIT];
	assign daily_ev = rise[CTL_DAILY_BIT];

	// idle counter, restarted by key activity
	logic [IDLE_W-1:0] idle_cnt, next_idle_cnt;
	logic idle_hit;
	logic [IDLE_W-1:0] idle_last;
	assign idle_last = IDLE_CYCLES - 1'b1; // last count before the light goes off
	logic idle_restart;
	assign idle_restart = key || !idle_en || !BACKLIGHT_ON; // key or dark light restarts
	always_comb begin
		next_idle_cnt = idle_cnt;
		idle_hit = 1'b0;
		if (idle_restart) begin
			next_idle_cnt = '0;
		end else if (idle_cnt >= idle_last) begin
			next_idle_cnt = '0;
			idle_hit = 1'b1;
		end else begin
			next_idle_cnt = idle_cnt + 1'b1;
		end
	end
	// registers the idle count
	always_ff @(posedge MCLK) begin
		if (RST) begin
			idle_cnt <= '0;
		end else begin
			idle_cnt <= next_idle_cnt;
		end
	end

	// backlight: blanked by bit 15 falling or idle, relit by rise, key or switch
	// control word is only read, never written back
	logic next_backlight;
	always_comb begin
		next_backlight = BACKLIGHT_ON;
		if (screen_off_ev || idle_hit) begin
			next_backlight = 1'b0;
		end
		if (screen_on_ev || key || scr_sw) begin
			next_backlight = 1'b1;
		end
	end
	// registers the backlight level
	always_ff @(posedge MCLK) begin
		if (RST) begin
			BACKLIGHT_ON <= 1'b1;
		end else begin
			BACKLIGHT_ON <= next_backlight;
		end
	end

	// one-cycle print pulses on qualifying rises
	logic next_hist, next_daily;
	always_comb begin
		next_hist = hist_ev;
		next_daily = daily_ev;
	end
	// registers the print pulses
	always_ff @(posedge MCLK) begin
		if (RST) begin
			HIST_PRINT <= 1'b0;
			DAILY_PRINT <= 1'b0;
		end else begin
			HIST_PRINT <= next_hist;
			DAILY_PRINT <= next_daily;
		end
	end

	// delayed copy of the entry pin for its rising edge
	logic entered_d, next_entered_d;
	always_comb begin
		next_entered_d = entered;
	end
	// registers the delayed entry pin
	always_ff @(posedge MCLK) begin
		if (RST) begin
			entered_d <= 1'b0;
		end else begin
			entered_d <= next_entered_d;
		end
	end
	logic new_entry;
	assign new_entry = entered && !entered_d; // one capture per finished entry

	// numeral strobe and updated entry word
	tswx_ntf_type ntf_state, next_ntf_state;
	logic [WORD_W-1:0] next_entry;
	always_comb begin
		next_ntf_state = ntf_state;
		next_entry = ENTRY_WORD;
		case (ntf_state)
			TSWX_NTF_IDLE: begin
				if (new_entry) begin
					next_entry = entry_word_of(NUM_ENTRY);
					next_ntf_state = TSWX_NTF_PENDING;
				end
			end
			TSWX_NTF_PENDING: begin
				if (new_entry) begin
					next_entry = entry_word_of(NUM_ENTRY);
				end else if (delivered) begin
					next_ntf_state = TSWX_NTF_IDLE;
				end
			end
			default: begin
				next_ntf_state = TSWX_NTF_IDLE;
			end
		endcase
	end
	// registers the strobe state and the entry word
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ntf_state <= TSWX_NTF_IDLE;
			ENTRY_WORD <= WORD_RESET;
		end else begin
			ntf_state <= next_ntf_state;
			ENTRY_WORD <= next_entry;
		end
	end

	// notify word: run bit and strobe bit, all others zero
	logic [WORD_W-1:0] next_notify;
	always_comb begin
		next_notify = WORD_RESET;
		next_notify[NTF_STROBE_BIT] = (next_ntf_state == TSWX_NTF_PENDING);
		next_notify[NTF_RUN_BIT] = run_mode;
	end
	// registers the notify word
	always_ff @(posedge MCLK) begin
		if (RST) begin
			NOTIFY_WORD <= WORD_RESET;
		end else begin
			NOTIFY_WORD <= next_notify;
		end
	end

	// link relay area address mapped onto io word area
	logic [15:0] next_addr;
	logic [1:0] next_area;
	logic link_hit;
	assign link_hit = is_link_word(ADDR_AREA, ADDR_IN); // address inside the moved range
	always_comb begin
		next_addr = ADDR_IN;
		next_area = ADDR_AREA;
		if (link_hit) begin
			next_addr = link_to_io(ADDR_IN);
			next_area = AREA_IO;
		end
	end
	// registers the mapped address and area
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ADDR_OUT <= 16'h0000;
			ADDR_AREA_OUT <= AREA_OTHER;
		end else begin
			ADDR_OUT <= next_addr;
			ADDR_AREA_OUT <= next_area;
		end
	end
endmodule
`default_nettype wire

/* tswx_chk.sv */
// checker for the status word exchange ports
`timescale 1ns/1ps
`default_nettype none
module tswx_chk
	import tswx_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [15:0] CTL_WORD,
	input wire logic [1:0] ADDR_AREA,
	input wire logic [15:0] ADDR_IN,
	input wire logic [15:0] ADDR_OUT,
	input wire logic [1:0] ADDR_AREA_OUT,
	input wire logic [15:0] NOTIFY_WORD,
	input wire logic [15:0] ENTRY_WORD,
	input wire logic HIST_PRINT,
	input wire logic DAILY_PRINT
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// one-cycle prints, caused by a polled rise three edges back
	a_hist_once: assert property (HIST_PRINT |=> !HIST_PRINT) else $error("hist long");
	a_daily_once: assert property (DAILY_PRINT |=> !DAILY_PRINT) else $error("daily long");
	a_hist_cause: assert property (HIST_PRINT |-> $past(CTL_WORD[5], 3)) else $error("hist");
	a_daily_cause: assert property (DAILY_PRINT |-> $past(CTL_WORD[4], 3)) else $error("daily");
	// notify holds run and strobe only, entry is three bcd digits
	a_notify_bits: assert property ((NOTIFY_WORD & 16'h77FF) == 16'h0000) else $error("ntf");
	a_entry_bcd: assert property (ENTRY_WORD[15:12] == 4'h0 && ENTRY_WORD[11:8] < 4'hA &&
		ENTRY_WORD[7:4] < 4'hA && ENTRY_WORD[3:0] < 4'hA) else $error("bcd");
	// address mapping one cycle later
	a_link_map: assert property (ADDR_AREA == AREA_LINK && ADDR_IN <= LINK_AREA_LAST |=>
		ADDR_OUT == $past(ADDR_IN) + LINK_TO_IO_BASE && ADDR_AREA_OUT == AREA_IO) else $error("map");
	a_io_pass: assert property (ADDR_AREA == AREA_IO |=> ADDR_OUT == $past(ADDR_IN)) else $error("io");
	c_hist: cover property (HIST_PRINT);
	c_daily: cover property (DAILY_PRINT);
	c_strobe: cover property (NOTIFY_WORD[11]);
endmodule
`default_nettype wire

/* tswx_plc.sv */
// controller memory model polled by the terminal
`timescale 1ns/1ps
`default_nettype none
module tswx_plc (
	input wire logic mclk,
	input wire logic [15:0] notify_word,
	input wire logic [15:0] entry_word,
	output logic [15:0] ctl_word,
	output logic ctl_poll,
	output logic [15:0] got_entry
);
	logic seen;
	// polled every cycle; word changed only by the controller program
	assign ctl_poll = 1'b1;
	task automatic set_ctl(input logic [15:0] v);
		ctl_word <= v;
	endtask
	// fetch the entry number on the strobe rise
	always @(posedge mclk) begin
		if (notify_word[11] && !seen) begin
			got_entry <= entry_word;
		end
		seen <= notify_word[11];
	end
	initial begin
		ctl_word = 16'h8030;
		seen = 1'b0;
		got_entry = 16'h0000;
	end
endmodule
`default_nettype wire

/* test_terminal_status_word_exchange.sv */
// self-checking bench for the status word exchange
`timescale 1ns/1ps
`default_nettype none
module test_terminal_status_word_exchange;
	logic clk = 0, rst = 1, ent = 0, dlv = 0, key = 0, sw = 0, idle = 0, poll;
	logic [9:0] num = 10'd709;
	logic [1:0] area = 2'h0, aout;
	logic [15:0] ain = 16'h0000, ctl, aw, ntf, ew, got, nh, nd;
	logic bl, hp, dp;
	int err_count = 0, n_checks = 0, k;
	// control word, then expected hist, daily and light
	logic [18:0] rows [8] = '{{16'h8030, 3'b001}, {16'h8000, 3'b001}, {16'h8010, 3'b011},
		{16'h8030, 3'b101}, {16'h0030, 3'b000}, {16'h8030, 3'b001}, {16'h8000, 3'b001},
		{16'h8030, 3'b111}};
	always #2 clk = ~clk;
	tswx_plc plc_u (.mclk(clk), .notify_word(ntf), .entry_word(ew), .ctl_word(ctl),
		.ctl_poll(poll), .got_entry(got));
	tswx_terminal_status_word_exchange #(.IDLE_CYCLES(32'd20)) dut_u (.MCLK(clk), .RST(rst),
		.CTL_WORD(ctl), .CTL_POLL(poll), .NUM_ENTERED(ent), .NUM_ENTRY(num), .NTF_DELIVERED(dlv),
		.RUN_MODE(1'b1), .KEY_PRESS(key), .SCREEN_SWITCH(sw), .IDLE_OFF_EN(idle),
		.ADDR_AREA(area), .ADDR_IN(ain), .ADDR_OUT(aw), .ADDR_AREA_OUT(aout),
		.NOTIFY_WORD(ntf), .ENTRY_WORD(ew), .BACKLIGHT_ON(bl), .HIST_PRINT(hp), .DAILY_PRINT(dp));
	task automatic step(input int n);
		repeat (n) begin
			@(negedge clk);
			nh += hp;
			nd += dp;
		end
	endtask
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic blank;
		@(posedge clk) plc_u.set_ctl(16'h8030);
		step(8);
		@(posedge clk) plc_u.set_ctl(16'h0030);
		step(8);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// table rows, then relight, entry, mapping and idle cases
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		step(1);
		chk("light rst", 16'h0001, {15'h0, bl});
		foreach (rows[i]) begin
			@(posedge clk) plc_u.set_ctl(rows[i][18:3]);
			nh = 0;
			nd = 0;
			step(8);
			chk("hist", {15'h0, rows[i][2]}, nh);
			chk("daily", {15'h0, rows[i][1]}, nd);
			chk("light", {15'h0, rows[i][0]}, {15'h0, bl});
			$display("row %0d done", i);
		end
		blank();
		@(posedge clk) key <= 1'b1;
		@(posedge clk) key <= 1'b0;
		step(8);
		chk("key light", 16'h0001, {15'h0, bl});
		blank();
		@(posedge clk) sw <= 1'b1;
		@(posedge clk) sw <= 1'b0;
		step(8);
		chk("switch light", 16'h0001, {15'h0, bl});
		@(posedge clk) ent <= 1'b1;
		@(posedge clk) ent <= 1'b0;
		for (k = 0; k < 10 && ntf[11] !== 1'b1; k++) @(negedge clk);
		if (k == 10) begin
			err_count++;
			tally_and_finish();
		end
		step(2);
		chk("entry", 16'h0709, ew);
		chk("notify", 16'h8800, ntf);
		chk("plc got", 16'h0709, got);
		@(posedge clk) dlv <= 1'b1;
		@(posedge clk) dlv <= 1'b0;
		step(8);
		chk("strobe clr", 16'h8000, ntf);
		@(posedge clk) area <= 2'h1;
		ain <= 16'h00C7;
		step(3);
		chk("map", 16'h04AF, aw);
		chk("map area", 16'h0000, {14'h0, aout});
		@(posedge clk) idle <= 1'b1;
		step(60);
		chk("idle off", 16'h0000, {15'h0, bl});
		$display("hand cases done");
		tally_and_finish();
	end
endmodule
bind tswx_terminal_status_word_exchange tswx_chk chk_u (.MCLK(MCLK), .RST(RST),
	.CTL_WORD(CTL_WORD), .ADDR_AREA(ADDR_AREA), .ADDR_IN(ADDR_IN), .ADDR_OUT(ADDR_OUT),
	.ADDR_AREA_OUT(ADDR_AREA_OUT), .NOTIFY_WORD(NOTIFY_WORD), .ENTRY_WORD(ENTRY_WORD),
	.HIST_PRINT(HIST_PRINT), .DAILY_PRINT(DAILY_PRINT));
`default_nettype wire
